// File: rtl/ewk_top.sv
// External request front end with standby wake, nonmaskable error handling and APB registers.
//
// Our own choices: the APB register port and the register offsets.
`timescale 1ns/1ps
module ewk_top
    import ewk_pkg::*;
#(
    parameter int NUM_PERIPH = 8
) (
    // Clock and reset
    input wire logic I_CLK_SYS,
    input wire logic I_RST,
    // APB slave
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [7:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    output logic [31:0] O_PRDATA,
    // External pins
    input wire logic I_NMI_PIN,
    input wire logic [NUM_PINS-1:0] I_EXT_REQ_PIN_N,
    input wire logic [NUM_PINS-1:0] I_PORT_INPUT_EN,
    // CPU side
    input wire logic I_STANDBY,
    input wire ewk_ack_s I_ACK,
    output logic O_NMI_REQ,
    output logic [NUM_PINS-1:0] O_PIN_REQ,
    output logic [NUM_PINS*PRIO_W-1:0] O_PIN_PRIO,
    output logic O_STANDBY_RELEASE,
    // Transfer engines
    output ewk_err_s O_ERR,
    // Peripheral sources
    input wire logic [NUM_PERIPH-1:0] I_PERIPH_FLAG,
    output logic [NUM_PERIPH-1:0] O_PERIPH_REQ,
    output logic [NUM_PERIPH-1:0] O_PERIPH_XFER_REQ
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic nmi_edge_q;
        logic [NUM_PINS*SENSE_W-1:0] sense_q;
        logic [NUM_PINS-1:0] enable_q;
        logic [NUM_PINS-1:0] flag_q;
        logic [NUM_PINS-1:0] seen_q;
        logic [NUM_PINS-1:0] wake_q;
        logic [NUM_PINS*PRIO_W-1:0] prio_q;
        logic [NUM_PERIPH-1:0] periph_en_q;
        logic nmi_pend_q;
        ewk_err_s err_q;
        ewk_wake_e wake_st_q;
        logic [CNT_W-1:0] cnt_q;
        logic release_q;
        logic [31:0] prdata_q;
    } ewk_state_s;

    ewk_state_s st_q;
    ewk_state_s st_d;

    logic [NUM_PINS-1:0] pin_trig;
    logic [NUM_PINS-1:0] pin_level;
    logic [NUM_PINS-1:0] sample_en;
    logic nmi_trig;
    logic nmi_unused_level;
    logic setup;
    logic access;
    logic mapped;

    // ************************************************************
    // Pin detectors
    // ************************************************************
    for (genvar gi = 0; gi < NUM_PINS; gi++) begin : g_pin
        // The port input control and, in standby, a zero wake bit gate detection; output direction plays no part.
        assign sample_en[gi] = I_PORT_INPUT_EN[gi] & ~(I_STANDBY & ~st_q.wake_q[gi]); // [RULE2] [RULE17]
        ewk_sense u_sense (
            .i_clk(I_CLK_SYS),
            .i_rst(I_RST),
            .i_pin(I_EXT_REQ_PIN_N[gi]),
            .i_sample_en(sample_en[gi]),
            .i_mode(st_q.sense_q[gi*SENSE_W +: SENSE_W]),
            .o_trig(pin_trig[gi]),
            .o_level(pin_level[gi])
        );
    end

    ewk_sense u_nmi (
        .i_clk(I_CLK_SYS),
        .i_rst(I_RST),
        .i_pin(I_NMI_PIN),
        .i_sample_en(1'b1),
        .i_mode(st_q.nmi_edge_q ? SENSE_RISE : SENSE_FALL), // [RULE8]
        .o_trig(nmi_trig),
        .o_level(nmi_unused_level)
    );

    // ************************************************************
    // Bus decode
    // ************************************************************
    assign setup = I_PSEL & ~I_PENABLE;
    assign access = I_PSEL & I_PENABLE;

    always_comb begin
        unique case (I_PADDR)
            OFF_CTRL, OFF_SENSE, OFF_ENABLE, OFF_STATUS, OFF_WAKE,
            OFF_PRIO_LO, OFF_PRIO_HI, OFF_PERIPH_EN, OFF_STATE: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        logic [NUM_PINS-1:0] set_f;
        logic [NUM_PINS-1:0] clr_f;
        logic [31:0] rd;
        logic wake_hit;
        set_f = '0;
        clr_f = '0;
        rd = ZERO_WORD;
        wake_hit = 1'b0;
        st_d = st_q;
        st_d.err_q = '0;
        st_d.release_q = 1'b0;

        // Read data is captured in the setup cycle so that it comes from a flop.
        if (setup && !I_PWRITE) begin
            unique case (I_PADDR)
                OFF_CTRL: rd[CTRL_NMI_EDGE_BIT] = st_q.nmi_edge_q;
                OFF_SENSE: rd[NUM_PINS*SENSE_W-1:0] = st_q.sense_q;
                OFF_ENABLE: rd[NUM_PINS-1:0] = st_q.enable_q;
                OFF_STATUS: rd[NUM_PINS-1:0] = st_q.flag_q;
                OFF_WAKE: rd[NUM_PINS-1:0] = st_q.wake_q; // [RULE1] [RULE4]
                OFF_PRIO_LO: begin
                    for (int i = 0; i < PRIO_PER_WORD; i++) begin
                        rd[i*PRIO_STRIDE +: PRIO_W] = st_q.prio_q[i*PRIO_W +: PRIO_W];
                    end
                end
                OFF_PRIO_HI: begin
                    for (int i = PRIO_PER_WORD; i < NUM_PINS; i++) begin
                        rd[(i-PRIO_PER_WORD)*PRIO_STRIDE +: PRIO_W] = st_q.prio_q[i*PRIO_W +: PRIO_W];
                    end
                end
                OFF_PERIPH_EN: rd[NUM_PERIPH-1:0] = st_q.periph_en_q;
                OFF_STATE: begin
                    rd[STATE_NMI_PEND_BIT] = st_q.nmi_pend_q;
                    rd[STATE_SETTLE_BIT] = (st_q.wake_st_q == ST_SETTLE);
                end
                default: rd = ZERO_WORD;
            endcase
            st_d.prdata_q = rd;
        end

        if (access && I_PWRITE) begin
            unique case (I_PADDR)
                OFF_CTRL: st_d.nmi_edge_q = I_PWDATA[CTRL_NMI_EDGE_BIT];
                OFF_SENSE: st_d.sense_q = I_PWDATA[NUM_PINS*SENSE_W-1:0];
                OFF_ENABLE: st_d.enable_q = I_PWDATA[NUM_PINS-1:0];
                // Only the zero bits of a word count, and only for flags read as one.
                OFF_STATUS: clr_f = ~I_PWDATA[NUM_PINS-1:0] & st_q.seen_q; // [RULE15]
                // Upper bits are not stored, so they always read back as zero.
                OFF_WAKE: st_d.wake_q = I_PWDATA[NUM_PINS-1:0]; // [RULE1] [RULE4]
                OFF_PRIO_LO: begin
                    for (int i = 0; i < PRIO_PER_WORD; i++) begin
                        st_d.prio_q[i*PRIO_W +: PRIO_W] = I_PWDATA[i*PRIO_STRIDE +: PRIO_W]; // [RULE13]
                    end
                end
                OFF_PRIO_HI: begin
                    for (int i = PRIO_PER_WORD; i < NUM_PINS; i++) begin
                        st_d.prio_q[i*PRIO_W +: PRIO_W] = I_PWDATA[(i-PRIO_PER_WORD)*PRIO_STRIDE +: PRIO_W]; // [RULE13]
                    end
                end
                OFF_PERIPH_EN: st_d.periph_en_q = I_PWDATA[NUM_PERIPH-1:0]; // [RULE19]
                default: st_d.nmi_edge_q = st_q.nmi_edge_q;
            endcase
        end

        // Exception handling entry for a pin clears edge flags, and level flags once the pin is high.
        if (I_ACK.valid && !I_ACK.nmi && (I_ACK.pin < PIN_IDX_W'(NUM_PINS))) begin
            if ((st_q.sense_q[I_ACK.pin*SENSE_W +: SENSE_W] != SENSE_LOW) || pin_level[I_ACK.pin]) begin
                clr_f[I_ACK.pin] = 1'b1; // [RULE16]
            end
        end

        // A trigger in the cycle of a clear keeps the flag set.
        set_f = pin_trig; // [RULE14]
        st_d.flag_q = set_f | (st_q.flag_q & ~clr_f); // [RULE14]
        st_d.seen_q = st_q.seen_q & st_d.flag_q;
        if (access && !I_PWRITE && (I_PADDR == OFF_STATUS)) begin
            st_d.seen_q = st_d.seen_q | (st_q.prdata_q[NUM_PINS-1:0] & st_q.flag_q); // [RULE15]
        end

        // Nonmaskable request: held until the CPU takes it, and reported as an error.
        if (nmi_trig) begin
            st_d.nmi_pend_q = 1'b1; // [RULE7]
            st_d.err_q = '{xfer_err_set: 1'b1, dma0_err_set: 1'b1, dma_stop_all: 1'b1}; // [RULE9]
        end else if (I_ACK.valid && I_ACK.nmi) begin
            st_d.nmi_pend_q = 1'b0;
        end

        // Standby release waits out the oscillator settling time.
        wake_hit = nmi_trig | (|(pin_trig & st_q.wake_q)); // [RULE6]
        unique case (st_q.wake_st_q)
            ST_RUN: begin
                if (I_STANDBY && wake_hit) begin
                    st_d.wake_st_q = ST_SETTLE; // [RULE3]
                    st_d.cnt_q = CNT_W'(SETTLE_CYCLES - 1);
                end
            end
            ST_SETTLE: begin
                if (st_q.cnt_q == '0) begin
                    st_d.release_q = 1'b1; // [RULE3]
                    st_d.wake_st_q = ST_RUN;
                end else begin
                    st_d.cnt_q = st_q.cnt_q - CNT_W'(1);
                end
            end
        endcase
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge I_CLK_SYS) begin
        if (I_RST) begin
            st_q <= '0;
            st_q.wake_q <= WAKE_RESET[NUM_PINS-1:0];
            st_q.wake_st_q <= ST_RUN;
        end else begin
            st_q <= st_d;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign O_PREADY = access;
    assign O_PSLVERR = access & ~mapped;
    assign O_PRDATA = st_q.prdata_q;
    assign O_NMI_REQ = st_q.nmi_pend_q; // [RULE7]
    assign O_PIN_REQ = st_q.flag_q & st_q.enable_q; // [RULE12]
    assign O_PIN_PRIO = st_q.prio_q; // [RULE13]
    assign O_STANDBY_RELEASE = st_q.release_q;
    assign O_ERR = st_q.err_q;
    // The transfer engines run their own activation priority; this block only gates the source.
    assign O_PERIPH_REQ = I_PERIPH_FLAG & st_q.periph_en_q; // [RULE19]
    assign O_PERIPH_XFER_REQ = I_PERIPH_FLAG & st_q.periph_en_q; // [RULE20]

endmodule

// File: rtl/ewk_pkg.sv
// Package with constants and types of the external request and standby wake block.
// Function
// RULE1: Wake enable register, one bit per pin.
// RULE2: Wake bit zero: pin not sampled in standby.
// RULE3: Wake bit one: leave standby after settling.
// RULE4: Wake bits 15 to 12 read zero.
// RULE5: Software keeps wake pins off transfer activation.
// RULE6: Thirteen sources, all may release standby.
// RULE7: Nonmaskable request always accepted, top priority.
// RULE8: Control bit picks nonmaskable rising or falling.
// RULE9: Nonmaskable sets error flags, stops DMA channels.
// RULE10: Two-bit sense per pin selects trigger.
// RULE11: Sense 00 low, 01 fall, 10 rise, 11 both.
// RULE12: Per-pin enable gates request to CPU.
// RULE13: Pin priority comes from programmable setting.
// RULE14: Per-pin flag set by trigger, software clears.
// RULE15: Flag clears by writing 0 after reading 1.
// RULE16: Edge flags clear on exception handling.
// RULE17: Detection gated by port input control, not port direction.
// RULE18: Level source holds pin low until handling.
// RULE19: Peripheral request only while its enable set.
// RULE20: Peripheral requests also activate transfer engines.
// RULE21: Pins synchronised before edge or level detection.
package ewk_pkg;

    // ************************************************************
    // Sizes
    // ************************************************************
    localparam int NUM_PINS = 12;
    localparam int PRIO_W = 3;
    localparam int PRIO_STRIDE = 4;
    localparam int PRIO_PER_WORD = 8;
    localparam int SENSE_W = 2;
    localparam int PIN_IDX_W = 4;

    // ************************************************************
    // Register offsets and layouts
    // ************************************************************
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_SENSE = 8'h04;
    localparam logic [7:0] OFF_ENABLE = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0c;
    localparam logic [7:0] OFF_WAKE = 8'h10;
    localparam logic [7:0] OFF_PRIO_LO = 8'h14;
    localparam logic [7:0] OFF_PRIO_HI = 8'h18;
    localparam logic [7:0] OFF_PERIPH_EN = 8'h1c;
    localparam logic [7:0] OFF_STATE = 8'h20;
    localparam int CTRL_NMI_EDGE_BIT = 0;
    localparam int STATE_NMI_PEND_BIT = 0;
    localparam int STATE_SETTLE_BIT = 1;
    localparam logic [15:0] WAKE_RESET = 16'h0000;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

    // ************************************************************
    // Sense encodings, rise bit on top
    // ************************************************************
    localparam logic [1:0] SENSE_LOW = 2'h0;
    localparam logic [1:0] SENSE_FALL = 2'h1;
    localparam logic [1:0] SENSE_RISE = 2'h2;
    localparam logic [1:0] SENSE_BOTH = 2'h3;

    // ************************************************************
    // Oscillation settling time
    // ************************************************************
    localparam int CLK_MHZ = 200;
    localparam int OSC_SETTLE_NS = 8000;
    localparam int SETTLE_CYCLES = (OSC_SETTLE_NS * CLK_MHZ + 999) / 1000;
    localparam int CNT_W = 12;

    typedef enum logic [0:0] {
        ST_RUN = 1'b0,
        ST_SETTLE = 1'b1
    } ewk_wake_e;

    // ************************************************************
    // Carriers
    // ************************************************************
    typedef struct packed {
        logic valid;
        logic nmi;
        logic [PIN_IDX_W-1:0] pin;
    } ewk_ack_s;

    typedef struct packed {
        logic xfer_err_set;
        logic dma0_err_set;
        logic dma_stop_all;
    } ewk_err_s;

endpackage

// File: rtl/ewk_sense.sv
// One request pin: synchroniser and sense detector.
`timescale 1ns/1ps
module ewk_sense
    import ewk_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Pin and control
    input wire logic i_pin,
    input wire logic i_sample_en,
    input wire logic [1:0] i_mode,
    // Results
    output logic o_trig,
    output logic o_level
);

    typedef struct packed {
        logic meta;
        logic sync;
        logic prev;
        logic armed;
    } ewk_sense_s;

    ewk_sense_s s_q;
    ewk_sense_s s_d;
    logic trig;

    always_comb begin
        s_d = s_q;
        trig = 1'b0;
        // A disabled pin is not sampled at all; rearming avoids a false edge on resume.
        if (i_sample_en) begin
            s_d.meta = i_pin; // [RULE21]
            s_d.sync = s_q.meta; // [RULE21]
            s_d.prev = s_q.sync;
            s_d.armed = 1'b1;
            if (s_q.armed) begin
                unique case (i_mode) // [RULE10]
                    SENSE_LOW: trig = ~s_q.sync; // [RULE11]
                    SENSE_FALL: trig = s_q.prev & ~s_q.sync; // [RULE11]
                    SENSE_RISE: trig = ~s_q.prev & s_q.sync; // [RULE11]
                    SENSE_BOTH: trig = s_q.prev ^ s_q.sync; // [RULE11]
                endcase
            end
        end else begin
            s_d.armed = 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            s_q <= '{meta: 1'b1, sync: 1'b1, prev: 1'b1, armed: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign o_trig = trig;
    assign o_level = s_q.sync;

endmodule

// File: dv/ewk_checker.sv
// Port assertions for the external request front end.
`timescale 1ns/1ps
module ewk_checker
    import ewk_pkg::*;
#(
    parameter int NUM_PERIPH = 8
) (
    // Clock and reset
    input wire logic I_CLK_SYS,
    input wire logic I_RST,
    // Bus
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [7:0] I_PADDR,
    input wire logic O_PREADY,
    input wire logic O_PSLVERR,
    input wire logic [31:0] O_PRDATA,
    // Requests
    input wire ewk_ack_s I_ACK,
    input wire logic O_NMI_REQ,
    input wire ewk_err_s O_ERR,
    input wire logic O_STANDBY_RELEASE,
    input wire logic [NUM_PERIPH-1:0] I_PERIPH_FLAG,
    input wire logic [NUM_PERIPH-1:0] O_PERIPH_REQ,
    input wire logic [NUM_PERIPH-1:0] O_PERIPH_XFER_REQ
);
    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking @(posedge I_CLK_SYS); endclocking
    default disable iff (I_RST);
    sequence s_rd_setup;
        I_PSEL && !I_PENABLE && !I_PWRITE;
    endsequence
    sequence s_nmi_ack;
        O_NMI_REQ && I_ACK.valid && I_ACK.nmi;
    endsequence
    AST_APB_READY: assert property (I_PSEL && I_PENABLE |-> O_PREADY)
        else $error("access cycle without ready");
    AST_WAKE_TOP_ZERO: assert property (s_rd_setup ##0 I_PADDR == OFF_WAKE |=> O_PRDATA[31:12] == 20'h0)
        else $error("wake register upper bits not zero");
    AST_UNMAPPED_READ: assert property (s_rd_setup ##0 I_PADDR > OFF_STATE ##1 I_PENABLE |-> O_PSLVERR && !O_PRDATA)
        else $error("unmapped read not refused");
    AST_PRDATA_HOLD: assert property (!(I_PSEL && !I_PENABLE && !I_PWRITE) |=> $stable(O_PRDATA))
        else $error("read data moved outside read setup");
    AST_NMI_ERR: assert property (O_ERR != 3'b000 |-> O_ERR == 3'b111 && O_NMI_REQ)
        else $error("error pulse incomplete");
    AST_NMI_RISE: assert property ($rose(O_NMI_REQ) |-> O_ERR == 3'b111)
        else $error("nonmaskable request without error pulse");
    AST_NMI_HOLD: assert property (O_NMI_REQ && !(I_ACK.valid && I_ACK.nmi) |=> O_NMI_REQ)
        else $error("nonmaskable request dropped without ack");
    AST_NMI_ACK: assert property (s_nmi_ack |=> !O_NMI_REQ || O_ERR == 3'b111)
        else $error("nonmaskable request kept after ack");
    AST_RELEASE_PULSE: assert property (O_STANDBY_RELEASE |=> !O_STANDBY_RELEASE)
        else $error("standby release longer than one cycle");
    AST_PERIPH_GATE: assert property ((O_PERIPH_REQ & ~I_PERIPH_FLAG) == '0)
        else $error("peripheral request without flag");
    AST_XFER_REQ: assert property (O_PERIPH_XFER_REQ == O_PERIPH_REQ)
        else $error("transfer activation differs from request");
endmodule

// File: dv/ewk_cpu_model.sv
// CPU core model that acknowledges pending requests after a set delay.
`timescale 1ns/1ps
module ewk_cpu_model
    import ewk_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Control, delay of at least one cycle
    input wire logic i_auto,
    input wire logic [3:0] i_delay,
    // Requests and answer
    input wire logic i_nmi_req,
    input wire logic [NUM_PINS-1:0] i_pin_req,
    output ewk_ack_s o_ack
);
    // ************************************************************
    // Acknowledge
    // ************************************************************
    ewk_ack_s ack_q = '0;
    logic [3:0] wait_q = '0;
    assign o_ack = ack_q;
    // The wait restarts after each ack, so a request still visible for a cycle is not taken twice.
    always @(posedge i_clk) begin
        ack_q <= '0;
        if (i_rst || !i_auto || !(i_nmi_req || |i_pin_req) || ack_q.valid) begin
            wait_q <= '0;
        end else if (wait_q < i_delay) begin
            wait_q <= wait_q + 4'h1;
        end else begin
            wait_q <= '0;
            ack_q.valid <= 1'b1;
            ack_q.nmi <= i_nmi_req;
            for (int i = NUM_PINS - 1; i >= 0; i--) begin
                if (i_pin_req[i]) begin
                    ack_q.pin <= 4'(i);
                end
            end
        end
    end
endmodule

// File: dv/external_irq_standby_wake_tb.sv
// Self-checking testbench of the external request front end.
`timescale 1ns/1ps
module external_irq_standby_wake_tb;
    import ewk_pkg::*;
    // ************************************************************
    // Signals
    // ************************************************************
    logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, nmi = 1, stby = 0, auto_ack = 0, err_q;
    logic [7:0] paddr = '0, pflag = '0;
    logic [31:0] pwdata = '0, rd, prdata;
    logic [11:0] pin_n = '1, in_en = '1, pin_req;
    logic [3:0] ack_dly = 4'h2;
    logic pready, pslverr, nmi_req, rel;
    logic [35:0] prio;
    logic [7:0] preq, pxreq;
    ewk_err_s err;
    ewk_ack_s ack;
    int miscompares = 0, num_checks = 0;
    initial begin
        forever #2.5 clk = ~clk;
    end
    ewk_top dut_u (.I_CLK_SYS(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
        .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .O_PRDATA(prdata),
        .I_NMI_PIN(nmi), .I_EXT_REQ_PIN_N(pin_n), .I_PORT_INPUT_EN(in_en), .I_STANDBY(stby), .I_ACK(ack),
        .O_NMI_REQ(nmi_req), .O_PIN_REQ(pin_req), .O_PIN_PRIO(prio), .O_STANDBY_RELEASE(rel), .O_ERR(err),
        .I_PERIPH_FLAG(pflag), .O_PERIPH_REQ(preq), .O_PERIPH_XFER_REQ(pxreq));
    ewk_cpu_model cpu_u (.i_clk(clk), .i_rst(rst), .i_auto(auto_ack), .i_delay(ack_dly),
        .i_nmi_req(nmi_req), .i_pin_req(pin_req), .o_ack(ack));
    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Zero wait states are expected, yet the master waits for ready under a bound.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1;
        pen <= 0;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (!pready && n < 50);
        if (!pready) begin
            miscompares++;
            report_and_stop;
        end
        rd = prdata;
        err_q = pslverr;
        psel <= 0;
        pen <= 0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        apb(0, a, 0);
        chk(rd, e);
    endtask
    task automatic wait_rel(output int n);
        n = 0;
        while (!rel && n < 2000) begin
            @(posedge clk);
            n++;
        end
        if (!rel) begin
            miscompares++;
            report_and_stop;
        end
    endtask
    // ************************************************************
    // Tests
    // ************************************************************
    initial begin
        int n;
        repeat (4) @(posedge clk);
        rst <= 0;
        for (int a = 0; a <= 32; a += 4) rdchk(8'(a), 0);
        apb(1, OFF_WAKE, 32'hffff_ffff);
        rdchk(OFF_WAKE, 32'hfff);
        rdchk(8'h24, 0);
        chk(err_q, 1);
        apb(1, OFF_WAKE, 0);
        $display("test registers done");
        apb(1, OFF_ENABLE, 32'hfff);
        for (int m = 0; m < 4; m++) begin
            apb(1, OFF_SENSE, 32'(m));
            pin_n[0] <= 0;
            repeat (5) @(posedge clk);
            rdchk(OFF_STATUS, 32'(m != 2));
            chk(pin_req[0], m != 2);
            apb(1, OFF_STATUS, 0);
            pin_n[0] <= 1;
            repeat (5) @(posedge clk);
            rdchk(OFF_STATUS, 32'(m != 1));
            apb(1, OFF_STATUS, 0);
            rdchk(OFF_STATUS, 0);
        end
        $display("test sense done");
        apb(1, OFF_SENSE, 32'h0055_5555);
        pin_n[1] <= 0;
        repeat (5) @(posedge clk);
        apb(1, OFF_STATUS, 0);
        apb(1, OFF_STATUS, 32'hfff);
        rdchk(OFF_STATUS, 32'h2);
        apb(1, OFF_ENABLE, 0);
        @(posedge clk);
        chk(pin_req, 0);
        apb(1, OFF_STATUS, 0);
        rdchk(OFF_STATUS, 0);
        in_en[3] <= 0;
        pin_n[3] <= 0;
        repeat (5) @(posedge clk);
        rdchk(OFF_STATUS, 0);
        in_en[3] <= 1;
        repeat (5) @(posedge clk);
        // The pin fell while it was not sampled, so the edge is taken once sampling resumes.
        rdchk(OFF_STATUS, 32'h8);
        apb(1, OFF_ENABLE, 32'hfff);
        auto_ack <= 1;
        for (int k = 0; k < 2; k++) begin
            ack_dly <= k ? 4'hf : 4'h2;
            pin_n[6 + k] <= 0;
            repeat (24) @(posedge clk);
            rdchk(OFF_STATUS, 0);
        end
        $display("test flags done");
        for (int e = 0; e < 2; e++) begin
            apb(1, OFF_CTRL, 32'(e));
            nmi <= e[0];
            n = 0;
            while (err == 3'b000 && n < 20) begin
                @(posedge clk);
                n++;
            end
            if (err == 3'b000) begin
                miscompares++;
                report_and_stop;
            end
            chk(err, 3'h7);
            chk(nmi_req, 1);
            repeat (20) @(posedge clk);
            chk(nmi_req, 0);
        end
        $display("test nonmaskable done");
        stby <= 1;
        apb(1, OFF_WAKE, 32'h20);
        pin_n[4] <= 0;
        n = 0;
        repeat (2000) begin
            @(posedge clk);
            if (rel !== 1'b0) n++;
        end
        chk(n, 0);
        rdchk(OFF_STATUS, 0);
        pin_n[5] <= 0;
        wait_rel(n);
        chk(n >= 1600 && n <= 1610, 1);
        nmi <= 0;
        repeat (4) @(posedge clk);
        nmi <= 1;
        wait_rel(n);
        chk(n >= 1600 && n <= 1610, 1);
        stby <= 0;
        $display("test standby done");
        apb(1, OFF_PRIO_LO, 32'h7654_3210);
        apb(1, OFF_PRIO_HI, 32'h0000_3210);
        repeat (2) @(posedge clk);
        chk(prio, 36'h688_fac688);
        pflag <= 8'h3c;
        apb(1, OFF_PERIPH_EN, 32'h5a);
        @(posedge clk);
        chk(preq, 8'h18);
        chk(pxreq, 8'h18);
        $display("test priority and peripherals done");
        report_and_stop;
    end
endmodule
bind ewk_top ewk_checker #(.NUM_PERIPH(NUM_PERIPH)) chk_u (.I_CLK_SYS(I_CLK_SYS), .I_RST(I_RST),
    .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .O_PREADY(O_PREADY),
    .O_PSLVERR(O_PSLVERR), .O_PRDATA(O_PRDATA), .I_ACK(I_ACK), .O_NMI_REQ(O_NMI_REQ), .O_ERR(O_ERR),
    .O_STANDBY_RELEASE(O_STANDBY_RELEASE), .I_PERIPH_FLAG(I_PERIPH_FLAG), .O_PERIPH_REQ(O_PERIPH_REQ),
    .O_PERIPH_XFER_REQ(O_PERIPH_XFER_REQ));
